// file: hdl/utf_cfg.svh
/*
 * Register map, field positions, reset values and trigger tables of the
 * UART trigger and frame format block.
 * Assumes it is included by bare name from every file that needs a constant.
 */
`ifndef UTF_CFG_SVH
`define UTF_CFG_SVH

// ****************************************************************
// register byte addresses (one aligned 32-bit word each)
// ****************************************************************
`define UTF_ADDR_LFC       8'h00
`define UTF_ADDR_FSC       8'h04
`define UTF_ADDR_FTC       8'h08
`define UTF_ADDR_TPV       8'h0c
`define UTF_ADDR_EFE       8'h10
`define UTF_ADDR_STAT      8'h14

// ****************************************************************
// field positions
// ****************************************************************
`define UTF_FSC_EN         0
`define UTF_FSC_RXFLUSH    1
`define UTF_FSC_TXFLUSH    2
`define UTF_FSC_DMA        3
`define UTF_FSC_TX_LSB     4
`define UTF_FSC_RX_LSB     6
`define UTF_FTC_TBL_LSB    4
`define UTF_FTC_TXSEL      7
`define UTF_EFE_ENH        4
`define UTF_LFC_STOP       2
`define UTF_LFC_PAR_EN     3
`define UTF_LFC_EVEN       4
`define UTF_LFC_FORCE      5
`define UTF_STAT_TX_LSB    8
`define UTF_STAT_RXIRQ     16
`define UTF_STAT_TXIRQ     17
`define UTF_STAT_FIFOEN    18

// ****************************************************************
// reset values and fixed figures
// ****************************************************************
`define UTF_LFC_RST        8'h00
`define UTF_FTC_RST        8'h00
`define UTF_EFE_RST        8'h00
`define UTF_TPV_RST        8'h01
`define UTF_MIN_BITS       4'h5
`define UTF_STOP_ONE       3'h2
`define UTF_STOP_ONE_HALF  3'h3
`define UTF_STOP_TWO       3'h4
`define UTF_RESP_OKAY      2'h0
`define UTF_RESP_SLVERR    2'h2

// ****************************************************************
// trigger tables, one byte per code, code 11 in the top byte
// ****************************************************************
`define UTF_RX_TBL_A       32'h0e08_0401
`define UTF_TX_TBL_A       32'h0101_0101
`define UTF_RX_TBL_B       32'h1c18_1008
`define UTF_TX_TBL_B       32'h1e18_0810
`define UTF_RX_TBL_C       32'h3c38_1008
`define UTF_TX_TBL_C       32'h3820_1008

`endif

// file: hdl/utf_pkg.sv
/*
 * Types shared by the trigger and frame format block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package utf_pkg;

  // trigger table selection
  typedef enum logic [1:0] {
    UTF_TBL_A = 2'h0,
    UTF_TBL_B = 2'h1,
    UTF_TBL_C = 2'h2,
    UTF_TBL_D = 2'h3
  } utf_table_e;

  // a trigger level in characters
  typedef logic [7:0] utf_lvl_t;

endpackage

// file: hdl/utf_parity.sv
/*
 * Parity of one character over the programmed number of data bits.
 * Assumes the word length code and parity controls are stable registers.
 */
module utf_parity (
  // character
  input  wire logic [7:0] data,
  input  wire logic [1:0] word_code,
  // parity controls
  input  wire logic       par_en,
  input  wire logic       even_sel,
  input  wire logic       force_sel,
  // result
  output logic            parity
);

  logic [7:0] mask;
  logic       ones;

  // bits above the word length never reach the line, so they are masked out
  // RQ20: programmed bits only
  always_comb begin
    unique case (word_code)
      2'h0: mask = 8'h1f;
      2'h1: mask = 8'h3f;
      2'h2: mask = 8'h7f;
      2'h3: mask = 8'hff;
    endcase
    ones = ^(data & mask);
  end

  // parity selection
  always_comb begin
    if (!par_en) begin
      parity = 1'b0;
    end else if (force_sel) begin
      // RQ14: forced mark
      // RQ15: forced space
      parity = ~even_sel;
    end else if (even_sel) begin
      // RQ13: even count
      parity = ones;
    end else begin
      // RQ12: odd count
      parity = ~ones;
    end
  end

endmodule

// file: hdl/utf_top.sv
/*
 * UART trigger level selection and serial character format control,
 * reached over an AXI4-Lite slave port.
 * Assumes the FIFO counts and the serial data come from logic on ref_clk.
 */
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
// How it works
// RQ1: two-bit receive trigger code, reset gives one
// RQ2: receive interrupt when count reaches trigger
// RQ3: table select field picks trigger table
// RQ4: one table selection shared by both directions
// RQ5: table A: receive 1/4/8/14, transmit one
// RQ6: tables B and C give listed levels
// RQ7: table D receive level from program value
// RQ8: table D transmit level from program value
// RQ9: word length code gives 5 to 8 bits
// RQ10: stop bit one, one-and-half, or two
// RQ11: parity bit sent and checked when enabled
// RQ12: odd parity is the default mode
// RQ13: even parity generated and checked
// RQ14: forced mark parity bit
// RQ15: forced space parity bit
// RQ16: remote end must check same parity
// RQ17: transmit interrupt below trigger or emptied
// RQ18: setup writes ignored unless enable bit set
// RQ19: transmit trigger needs enhanced enable bit
// RQ20: parity over programmed bits, after data
`include "utf_cfg.svh"

module utf_top #(
  parameter int FIFO_DEPTH = 128,
  parameter int CNT_W      = 8
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  // axi4-lite write
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // fifo side
  input  wire logic [CNT_W-1:0]     rx_fifo_count,
  input  wire logic [CNT_W-1:0]     tx_fifo_count,
  input  wire logic                 tx_irq_clear,
  output utf_pkg::utf_lvl_t         rx_trigger_level,
  output utf_pkg::utf_lvl_t         tx_trigger_level,
  output logic                      rx_trigger_irq,
  output logic                      tx_trigger_irq,
  output logic                      fifo_enable,
  output logic                      dma_mode,
  output logic                      rx_fifo_flush,
  output logic                      tx_fifo_flush,
  // character format
  output logic [3:0]                data_bits,
  output logic [2:0]                stop_half_bits,
  output logic                      parity_enable,
  // parity generation and check
  input  wire logic [7:0]           tx_data,
  output logic                      tx_parity_bit,
  input  wire logic [7:0]           rx_data,
  input  wire logic                 rx_parity_in,
  output logic                      rx_parity_error
);
  import utf_pkg::*;

  // the largest table entry is 60 characters
  if (FIFO_DEPTH < 64 || (1 << CNT_W) <= FIFO_DEPTH) begin : g_bad_size
    $error("utf_top: fifo depth or count width cannot hold the trigger levels");
  end

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [7:0]  lfc_q;
  logic [1:0]  rx_code_q;
  logic [1:0]  tx_code_q;
  logic        fifo_en_q;
  logic        dma_q;
  logic        rx_flush_q;
  logic        tx_flush_q;
  logic [7:0]  ftc_q;
  logic [7:0]  efe_q;
  utf_lvl_t    rx_prog_q;
  utf_lvl_t    tx_prog_q;
  utf_lvl_t    rx_lvl_q;
  utf_lvl_t    tx_lvl_q;
  logic        rx_irq_q;
  logic        tx_irq_q;
  logic        tx_below_q;
  logic        tx_over_q;
  logic [CNT_W-1:0] tx_cnt_q;
  logic [3:0]  bits_q;
  logic [2:0]  stop_q;
  logic        par_en_q;
  logic        tx_par_q;
  logic        rx_err_q;
  logic        tx_par_d;
  logic        rx_par_exp;
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        aw_ok;
  logic        w_ok;
  logic        do_wr;
  logic [7:0]  wr_addr;
  logic [31:0] wd;
  logic        wr_lane0;
  logic [2:0]  wsel;
  logic [2:0]  rsel;
  logic        reg_we;
  logic        tx_below;
  utf_table_e  tbl;

  // ****************************************************************
  // helpers
  // ****************************************************************

  // register index of a byte address, 3'h7 when unmapped
  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    logic [2:0] idx;
    idx = 3'h7;
    unique case (addr)
      `UTF_ADDR_LFC:  idx = 3'h0;
      `UTF_ADDR_FSC:  idx = 3'h1;
      `UTF_ADDR_FTC:  idx = 3'h2;
      `UTF_ADDR_TPV:  idx = 3'h3;
      `UTF_ADDR_EFE:  idx = 3'h4;
      `UTF_ADDR_STAT: idx = 3'h5;
      default:        idx = 3'h7;
    endcase
    return idx;
  endfunction

  // trigger level from the shared table for either direction
  function automatic utf_lvl_t trig_pick(input utf_table_e t, input logic [1:0] code,
                                         input logic is_tx, input utf_lvl_t prog);
    logic [31:0] row;
    row = 32'h0000_0000;
    unique case (t)
      UTF_TBL_A: row = is_tx ? `UTF_TX_TBL_A : `UTF_RX_TBL_A;
      UTF_TBL_B: row = is_tx ? `UTF_TX_TBL_B : `UTF_RX_TBL_B;
      UTF_TBL_C: row = is_tx ? `UTF_TX_TBL_C : `UTF_RX_TBL_C;
      UTF_TBL_D: row = 32'h0000_0000;
    endcase
    return (t == UTF_TBL_D) ? prog : row[{code, 3'b000} +: 8];
  endfunction

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // ****************************************************************
  // axi4-lite write channel
  // ****************************************************************

  // address and data may arrive in either order; the first one is parked
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign aw_ok    = aw_held_q || (s_axi_awvalid && s_axi_awready);
  assign w_ok     = w_held_q || (s_axi_wvalid && s_axi_wready);
  assign do_wr    = aw_ok && w_ok && !bvalid_q;
  assign wr_addr  = aw_held_q ? aw_addr_q : s_axi_awaddr;
  assign wd       = w_held_q ? w_data_q : s_axi_wdata;
  assign wr_lane0 = w_held_q ? w_strb_q[0] : s_axi_wstrb[0];
  assign wsel     = reg_index(wr_addr);
  // only byte lane 0 carries register bits
  assign reg_we   = do_wr && wr_lane0;

  // parking of write address and data
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (do_wr) begin
        aw_held_q <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (do_wr) begin
        w_held_q <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  // write response, one cycle after both halves are in
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `UTF_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wsel == 3'h7) ? `UTF_RESP_SLVERR : `UTF_RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  wr_resp_a: assert property (do_wr |=> s_axi_bvalid && !s_axi_awready)
    else $error("write response missing after a write");

  // ****************************************************************
  // axi4-lite read channel
  // ****************************************************************
  assign s_axi_arready = !rvalid_q;
  assign rsel          = reg_index(s_axi_araddr);

  // the setup register is write-only and reads as zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `UTF_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= (rsel == 3'h7) ? `UTF_RESP_SLVERR : `UTF_RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
      unique case (rsel)
        3'h0: rdata_q[7:0] <= lfc_q;
        3'h2: rdata_q[7:0] <= ftc_q;
        3'h3: rdata_q[7:0] <= ftc_q[`UTF_FTC_TXSEL] ? tx_prog_q : rx_prog_q;
        3'h4: rdata_q[7:0] <= efe_q;
        3'h5: begin
          rdata_q[7:0]                         <= rx_lvl_q;
          rdata_q[`UTF_STAT_TX_LSB +: 8]       <= tx_lvl_q;
          rdata_q[`UTF_STAT_RXIRQ]             <= rx_irq_q;
          rdata_q[`UTF_STAT_TXIRQ]             <= tx_irq_q;
          rdata_q[`UTF_STAT_FIFOEN]            <= fifo_en_q;
        end
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // ****************************************************************
  // control registers
  // ****************************************************************

  // format, table select, enhanced enable and program values
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lfc_q     <= `UTF_LFC_RST;
      ftc_q     <= `UTF_FTC_RST;
      efe_q     <= `UTF_EFE_RST;
      rx_prog_q <= `UTF_TPV_RST;
      tx_prog_q <= `UTF_TPV_RST;
    end else if (reg_we) begin
      if (wsel == 3'h0) lfc_q <= wd[7:0];
      // RQ3: table select stored
      if (wsel == 3'h2) ftc_q <= wd[7:0];
      if (wsel == 3'h4) efe_q <= wd[7:0];
      // RQ7: receive program value
      // RQ8: transmit program value
      if (wsel == 3'h3 && !ftc_q[`UTF_FTC_TXSEL]) rx_prog_q <= wd[7:0];
      if (wsel == 3'h3 && ftc_q[`UTF_FTC_TXSEL])  tx_prog_q <= wd[7:0];
    end
  end

  // fifo setup register; every field except the enable bit itself waits for the enable bit in the same write
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fifo_en_q  <= 1'b0;
      dma_q      <= 1'b0;
      rx_code_q  <= 2'h0;
      tx_code_q  <= 2'h0;
      rx_flush_q <= 1'b0;
      tx_flush_q <= 1'b0;
    end else begin
      rx_flush_q <= 1'b0;
      tx_flush_q <= 1'b0;
      if (reg_we && wsel == 3'h1) begin
        fifo_en_q <= wd[`UTF_FSC_EN];
        // RQ18: enable bit gates
        if (wd[`UTF_FSC_EN]) begin
          dma_q      <= wd[`UTF_FSC_DMA];
          rx_flush_q <= wd[`UTF_FSC_RXFLUSH];
          tx_flush_q <= wd[`UTF_FSC_TXFLUSH];
          // RQ1: receive code stored
          rx_code_q  <= wd[`UTF_FSC_RX_LSB +: 2];
          // RQ19: enhanced enable gates
          if (efe_q[`UTF_EFE_ENH]) tx_code_q <= wd[`UTF_FSC_TX_LSB +: 2];
        end
      end
    end
  end

  fsc_gate_a: assert property (reg_we && wsel == 3'h1 && !wd[`UTF_FSC_EN]
                               |=> $stable(rx_code_q) && $stable(tx_code_q)) // RQ18
    else $error("setup codes changed without the enable bit");
  efe_gate_a: assert property (reg_we && wsel == 3'h1 && !efe_q[`UTF_EFE_ENH]
                               |=> $stable(tx_code_q)) // RQ19
    else $error("transmit code changed without enhanced enable");

  // ****************************************************************
  // trigger levels
  // ****************************************************************
  assign tbl = utf_table_e'(ftc_q[`UTF_FTC_TBL_LSB +: 2]);

  // RQ4: one shared table
  // RQ5: table A levels
  // RQ6: tables B and C
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_lvl_q <= 8'h01;
      tx_lvl_q <= 8'h01;
    end else begin
      rx_lvl_q <= trig_pick(tbl, rx_code_q, 1'b0, rx_prog_q);
      tx_lvl_q <= trig_pick(tbl, tx_code_q, 1'b1, tx_prog_q);
    end
  end
  assign rx_trigger_level = rx_lvl_q;
  assign tx_trigger_level = tx_lvl_q;

  tbl_a_rx_a: assert property (tbl == UTF_TBL_A && rx_code_q == 2'h3
                               |=> rx_lvl_q == 8'd14) // RQ5
    else $error("table A receive code 3 is not 14");
  tbl_a_tx_a: assert property (tbl == UTF_TBL_A |=> tx_lvl_q == 8'd1) // RQ5
    else $error("table A transmit level is not 1");
  tbl_b_tx_a: assert property (tbl == UTF_TBL_B && tx_code_q == 2'h3
                               |=> tx_lvl_q == 8'd30) // RQ6
    else $error("table B transmit code 3 is not 30");
  tbl_c_rx_a: assert property (tbl == UTF_TBL_C && rx_code_q == 2'h3
                               |=> rx_lvl_q == 8'd60) // RQ6
    else $error("table C receive code 3 is not 60");
  tbl_d_prog_a: assert property (tbl == UTF_TBL_D |=> rx_lvl_q == $past(rx_prog_q)
                                 && tx_lvl_q == $past(tx_prog_q)) // RQ7
    else $error("table D levels do not follow the program values");

  // ****************************************************************
  // trigger interrupts
  // ****************************************************************
  assign tx_below = tx_fifo_count < CNT_W'(tx_lvl_q);

  // RQ2: receive level reached
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_irq_q <= 1'b0;
    end else begin
      rx_irq_q <= fifo_en_q && (rx_fifo_count >= CNT_W'(rx_lvl_q));
    end
  end

  // a new falling edge or an empty after a short reload sets, the set beats a clear
  // RQ17: transmit falls below
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_irq_q   <= 1'b0;
      tx_below_q <= 1'b1;
      tx_over_q  <= 1'b0;
      tx_cnt_q   <= '0;
    end else begin
      tx_below_q <= tx_below;
      tx_cnt_q   <= tx_fifo_count;
      if (tx_fifo_count == '0) begin
        tx_over_q <= 1'b0;
      end else if (!tx_below && tx_fifo_count != CNT_W'(tx_lvl_q)) begin
        tx_over_q <= 1'b1;
      end
      if (fifo_en_q && ((tx_below && !tx_below_q) ||
          (tx_fifo_count == '0 && tx_cnt_q != '0 && !tx_over_q))) begin
        tx_irq_q <= 1'b1;
      end else if (tx_irq_clear || !fifo_en_q) begin
        tx_irq_q <= 1'b0;
      end
    end
  end
  assign rx_trigger_irq = rx_irq_q;
  assign tx_trigger_irq = tx_irq_q;
  assign fifo_enable    = fifo_en_q;
  assign dma_mode       = dma_q;
  assign rx_fifo_flush  = rx_flush_q;
  assign tx_fifo_flush  = tx_flush_q;

  rx_irq_a: assert property (fifo_en_q && rx_fifo_count >= CNT_W'(rx_lvl_q)
                             |=> rx_trigger_irq) // RQ2
    else $error("receive interrupt missing at trigger level");
  tx_irq_a: assert property (fifo_en_q && tx_below && !tx_below_q
                             |=> tx_trigger_irq) // RQ17
    else $error("transmit interrupt missing when falling below trigger");

  // ****************************************************************
  // character format and parity
  // ****************************************************************

  // RQ9: word length
  // RQ10: stop length
  // RQ11: parity enable
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bits_q   <= `UTF_MIN_BITS;
      stop_q   <= `UTF_STOP_ONE;
      par_en_q <= 1'b0;
    end else begin
      bits_q   <= 4'(`UTF_MIN_BITS + {2'b00, lfc_q[1:0]});
      par_en_q <= lfc_q[`UTF_LFC_PAR_EN];
      if (!lfc_q[`UTF_LFC_STOP]) begin
        stop_q <= `UTF_STOP_ONE;
      end else if (lfc_q[1:0] == 2'h0) begin
        stop_q <= `UTF_STOP_ONE_HALF;
      end else begin
        stop_q <= `UTF_STOP_TWO;
      end
    end
  end
  assign data_bits      = bits_q;
  assign stop_half_bits = stop_q;
  assign parity_enable  = par_en_q;

  // the same generator serves sending and checking, so both use one format
  utf_parity u_tx_par (
    .data      (tx_data),
    .word_code (lfc_q[1:0]),
    .par_en    (lfc_q[`UTF_LFC_PAR_EN]),
    .even_sel  (lfc_q[`UTF_LFC_EVEN]),
    .force_sel (lfc_q[`UTF_LFC_FORCE]),
    .parity    (tx_par_d)
  );
  utf_parity u_rx_par (
    .data      (rx_data),
    .word_code (lfc_q[1:0]),
    .par_en    (lfc_q[`UTF_LFC_PAR_EN]),
    .even_sel  (lfc_q[`UTF_LFC_EVEN]),
    .force_sel (lfc_q[`UTF_LFC_FORCE]),
    .parity    (rx_par_exp)
  );

  // RQ11: check received parity
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_par_q <= 1'b0;
      rx_err_q <= 1'b0;
    end else begin
      tx_par_q <= tx_par_d;
      rx_err_q <= lfc_q[`UTF_LFC_PAR_EN] && (rx_parity_in != rx_par_exp);
    end
  end
  assign tx_parity_bit   = tx_par_q;
  assign rx_parity_error = rx_err_q;

  word_len_a: assert property (lfc_q[1:0] == 2'h3 |=> data_bits == 4'd8) // RQ9
    else $error("word code 3 does not give 8 bits");
  stop_half_a: assert property (lfc_q[`UTF_LFC_STOP] && lfc_q[1:0] == 2'h0
                                |=> stop_half_bits == 3'd3) // RQ10
    else $error("five-bit words do not get one and a half stop bits");
  par_force_a: assert property (lfc_q[`UTF_LFC_PAR_EN] && lfc_q[`UTF_LFC_FORCE]
                                |=> tx_parity_bit == !$past(lfc_q[`UTF_LFC_EVEN])) // RQ14
    else $error("forced parity bit has the wrong value");
  par_odd_a: assert property (lfc_q[`UTF_LFC_PAR_EN] && lfc_q[5:4] == 2'h0
                              && lfc_q[1:0] == 2'h3
                              |=> (^{$past(tx_data), tx_parity_bit}) == 1'b1) // RQ12
    else $error("odd parity does not give an odd count of ones");

endmodule

// file: bench/utf_remote.sv
/* Remote serial end: hands back a character with its parity bit.
   Assumes lfc mirrors the line format the host has programmed. */
module utf_remote (
  // clock
  input  wire logic       ref_clk,
  // format and stimulus
  input  wire logic [7:0] lfc,
  input  wire logic [7:0] ch,
  input  wire logic       bad,
  // toward the receiver
  output logic [7:0]      rx_data,
  output logic            rx_parity_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] m;
  logic       p;
  assign m = 8'hff >> (2'h3 - lfc[1:0]);
  assign p = ^(ch & m);
  always_ff @(posedge ref_clk) begin
    rx_data      <= ch ^ ~m;  // junk above the word must not matter
    rx_parity_in <= (lfc[5] ? ~lfc[4] : (lfc[4] ? p : ~p)) ^ bad;
  end
endmodule

// file: bench/uart_trigger_and_frame_format_tb.sv
/* Self-checking bench: AXI4-Lite host, fifo counts, remote end.
   Assumes one 20 MHz clock and the byte map of utf_cfg.svh. */
`include "utf_cfg.svh"
module uart_trigger_and_frame_format_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import utf_pkg::*;
  logic ref_clk = 0, resetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic bad = 0, clr = 0, awr, wrd, bv, arr, rv, rxi, txi, fen, tpar, perr, rxp, pen, dma;
  logic [7:0] awa = 0, ara = 0, rxc = 0, txc = 0, lfc = 0, ch = 0, rxd;
  logic [31:0] wd = 0, rdt;
  logic [1:0] bre, rre;
  logic [3:0] dbits;
  logic [2:0] stp;
  utf_lvl_t rxl, txl;
  int errors = 0, num_checks = 0;
  localparam logic [7:0] RXT [12] = '{8'h01, 8'h04, 8'h08, 8'h0e, 8'h08, 8'h10,
    8'h18, 8'h1c, 8'h08, 8'h10, 8'h38, 8'h3c};
  localparam logic [7:0] TXT [12] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h10, 8'h08,
    8'h18, 8'h1e, 8'h08, 8'h10, 8'h20, 8'h38};
  localparam logic [7:0] PM [5] = '{8'h08, 8'h18, 8'h28, 8'h38, 8'h00};
  utf_top dut (.ref_clk(ref_clk), .resetn(resetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
    .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rry), .rx_fifo_count(rxc),
    .tx_fifo_count(txc), .tx_irq_clear(clr), .rx_trigger_level(rxl), .tx_trigger_level(txl),
    .rx_trigger_irq(rxi), .tx_trigger_irq(txi), .fifo_enable(fen), .dma_mode(dma),
    .rx_fifo_flush(), .tx_fifo_flush(), .data_bits(dbits), .stop_half_bits(stp),
    .parity_enable(pen), .tx_data(ch), .tx_parity_bit(tpar), .rx_data(rxd),
    .rx_parity_in(rxp), .rx_parity_error(perr));
  utf_remote rem (.ref_clk(ref_clk), .lfc(lfc), .ch(ch), .bad(bad), .rx_data(rxd),
    .rx_parity_in(rxp));
  // ****************************************
  // bus cycles and judging
  // ****************************************
  task automatic stop_test;
    if (errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic tmo;
    errors++;
    stop_test();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // each channel released at its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (n = 0; n < 40 && bv !== 1'b1; n++) begin
      @(posedge ref_clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end
    bry <= 1'b0;
    if (n == 40) tmo();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (n = 0; n < 40 && rv !== 1'b1; n++) begin
      @(posedge ref_clk);
      if (arr) arv <= 1'b0;
    end
    q = rdt;
    r = rre;
    rry <= 1'b0;
    if (n == 40) tmo();
  endtask
  task automatic t_reset;
    logic [31:0] q;
    logic [1:0] r;
    rd(`UTF_ADDR_LFC, q, r);
    chk(q, 32'h0);
    chk(dbits, 4'h5);
    chk(stp, 3'h2);
    chk(rxl, 8'h01);
    chk(txl, 8'h01);
    rd(8'h3c, q, r);
    chk(r, 2'h2);
  endtask
  task automatic t_tables;
    wr(`UTF_ADDR_EFE, 32'h10);
    for (int i = 0; i < 12; i++) begin
      wr(`UTF_ADDR_FSC, {24'h0, i[1:0], i[1:0], 4'h1});
      wr(`UTF_ADDR_FTC, {26'h0, i[3:2], 4'h0});
      cyc(3);
      chk(rxl, RXT[i]);
      chk(txl, TXT[i]);
    end
  endtask
  task automatic t_tbl_d;
    wr(`UTF_ADDR_FTC, 32'h30);
    wr(`UTF_ADDR_TPV, 32'h22);
    wr(`UTF_ADDR_FTC, 32'hb0);
    wr(`UTF_ADDR_TPV, 32'h33);
    wr(`UTF_ADDR_FSC, 32'h01);
    cyc(3);
    chk(rxl, 8'h22);
    chk(txl, 8'h33);
  endtask
  task automatic t_ignore;
    wr(`UTF_ADDR_FTC, 32'h10);
    wr(`UTF_ADDR_FSC, 32'h01);
    wr(`UTF_ADDR_FSC, 32'hf8);
    cyc(3);
    chk(rxl, 8'h08);
    chk(dma, 1'b0);
    chk(fen, 1'b0);
    wr(`UTF_ADDR_EFE, 32'h0);
    wr(`UTF_ADDR_FSC, 32'h31);
    cyc(3);
    chk(txl, 8'h10);
  endtask
  task automatic t_format;
    for (int i = 0; i < 8; i++) begin
      wr(`UTF_ADDR_LFC, i);
      cyc(3);
      chk(dbits, 4'h5 + i[1:0]);
      chk(stp, !i[2] ? 3'h2 : (i[1:0] == 2'h0 ? 3'h3 : 3'h4));
    end
  endtask
  task automatic t_parity;
    logic [7:0] v;
    for (int m = 0; m < 5; m++) for (int w = 0; w < 4; w++) begin
      v = PM[m] | w[1:0];
      wr(`UTF_ADDR_LFC, v);
      lfc <= v;
      ch <= 8'hb5 ^ 8'(m);
      bad <= w[0];
      cyc(3);
      if (v[3]) chk(tpar, rxp ^ bad);
      chk(perr, v[3] & bad);
      chk(pen, v[3]);
    end
    bad <= 1'b0;
  endtask
  task automatic t_irq;
    wr(`UTF_ADDR_EFE, 32'h10);
    wr(`UTF_ADDR_FSC, 32'h49);
    rxc <= 8'h0f;
    txc <= 8'h11;
    cyc(3);
    chk(rxi, 1'b0);
    chk(dma, 1'b1);
    rxc <= 8'h10;
    txc <= 8'h10;
    cyc(3);
    chk(rxi, 1'b1);
    chk(txi, 1'b0);
    txc <= 8'h0f;
    cyc(3);
    chk(txi, 1'b1);
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    cyc(2);
    chk(txi, 1'b0);
    txc <= 8'h00;
    cyc(2);
    txc <= 8'h05;
    cyc(2);
    chk(txi, 1'b0);
    txc <= 8'h00;
    cyc(3);
    chk(txi, 1'b1);
  endtask
  // free-running clock, reset held ten cycles
  always #25 ref_clk = ~ref_clk;
  initial begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    t_tables();
    t_tbl_d();
    t_ignore();
    t_format();
    t_parity();
    t_irq();
    stop_test();
  end
endmodule
